//--- core/epi_pkg.sv
// constants for the external pin interrupt block
package epi_pkg;
    // register offsets on the 8-bit register port
    localparam logic [7:0] EPI_ADDR_FLAGS = 8'h1C;
    localparam logic [7:0] EPI_ADDR_MASK = 8'h1D;
    localparam logic [7:0] EPI_ADDR_SENSE = 8'h69;
    localparam logic [7:0] EPI_ADDR_PMASK0 = 8'h6B;
    localparam logic [7:0] EPI_ADDR_PMASK1 = 8'h6C;
    localparam logic [7:0] EPI_ADDR_PMASK2 = 8'h6D;
    localparam logic [7:0] EPI_ADDR_PMASK3 = 8'h6E;
    // field positions
    localparam int EPI_EXT_BIT = 0;
    localparam int EPI_GRP_BIT_LO = 4;
    localparam int EPI_NUM_GROUPS = 4;
    localparam int EPI_GRP_W = 8;
    localparam int EPI_NUM_PC = 31;
    // writable bits of each register
    localparam logic [7:0] EPI_MASK_WR_BITS = 8'hF1;
    localparam logic [7:0] EPI_SENSE_WR_BITS = 8'h03;
    localparam logic [7:0] EPI_PMASK3_WR_BITS = 8'h7F;
    // values after reset
    localparam logic [7:0] EPI_MASK_RST = 8'h00;
    localparam logic [7:0] EPI_SENSE_RST = 8'h00;
    localparam logic [7:0] EPI_FLAGS_RST = 8'h00;
    localparam logic [7:0] EPI_PMASK_RST = 8'h00;
    localparam logic [7:0] EPI_RDATA_RST = 8'h00;
    // sense selections
    localparam logic [1:0] EPI_SENSE_LOW = 2'h0;
    localparam logic [1:0] EPI_SENSE_ANY = 2'h1;
    localparam logic [1:0] EPI_SENSE_FALL = 2'h2;
    localparam logic [1:0] EPI_SENSE_RISE = 2'h3;
    // input sampling depth in clock cycles
    localparam int EPI_SYNC_STAGES = 3;
endpackage

//--- core/epi_ctrl.sv
// external pin and pin-change interrupt controller
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module epi_ctrl #(
    parameter bit FULL_PINS = 1'b1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // external pins
    input wire logic ext_irq_pin_in,
    input wire logic [epi_pkg::EPI_NUM_PC-1:0] pin_change_inputs_in,
    // processor side
    input wire logic global_irq_enable_in,
    input wire logic io_clk_run_in,
    input wire logic ext_irq_ack_in,
    input wire logic [epi_pkg::EPI_NUM_GROUPS-1:0] group_ack_in,
    output logic ext_irq_request_out,
    output logic [epi_pkg::EPI_NUM_GROUPS-1:0] pin_change_group_request_out,
    output logic wake_request_out
);
    import epi_pkg::*;

    // pin mask register select: hit flag and group index
    function automatic logic [2:0] pmask_sel(input logic [7:0] addr);
        logic [2:0] sel;
        sel = 3'h0;
        case (addr)
            EPI_ADDR_PMASK0: sel = 3'h4;
            EPI_ADDR_PMASK1: sel = 3'h5;
            EPI_ADDR_PMASK2: sel = 3'h6;
            EPI_ADDR_PMASK3: sel = 3'h7;
            default: sel = 3'h0;
        endcase
        return sel;
    endfunction

    // software state
    logic [7:0] mask_q; // group enables and pin enable
    logic [1:0] sense_q; // pin sense selection
    logic [7:0] pmask_q [EPI_NUM_GROUPS]; // per-input masks
    logic ext_flag_q; // pin flag
    logic [EPI_NUM_GROUPS-1:0] grp_flag_q; // group flags
    logic [7:0] rdata_q; // read data, one cycle late

    // input sampling chain: bit 0 is the pin, 31..1 the inputs
    logic [31:0] raw;
    logic [31:0] sync1_q;
    logic [31:0] sync2_q;
    logic [31:0] sync3_q;
    logic [31:0] filt_q; // agreed value
    logic [31:0] prev_q; // agreed value one cycle earlier

    // event terms
    logic [32:0] pc_chg; // top bit pads group 3 to a full byte
    logic [EPI_NUM_GROUPS-1:0] grp_set;
    logic [EPI_NUM_GROUPS-1:0] grp_en;
    logic [EPI_NUM_GROUPS-1:0] grp_live;
    logic ext_now;
    logic ext_rise;
    logic ext_fall;
    logic ext_set;
    logic level_mode;
    logic flag_wr;
    logic [7:0] flag_w1;
    logic [2:0] wsel;
    logic [2:0] rsel;
    logic [7:0] rd_d;
    logic [31:0] wake_diff;

    // the pad value is read back even when the pin is an output,
    // so a write to the pin's driver raises a request too
    assign raw = {pin_change_inputs_in, ext_irq_pin_in};

    // three-stage sampler; filt follows once stages 2 and 3 agree
    // it starts at zero, so high pins look like a change after reset;
    // all enables are clear by then, so no flag can come of it
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1_q <= 32'h00000000;
            sync2_q <= 32'h00000000;
            sync3_q <= 32'h00000000;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // agreement filter and previous-value copy
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            filt_q <= 32'h00000000;
            prev_q <= 32'h00000000;
        end else begin
            filt_q <= (sync3_q & ~(sync2_q ^ sync3_q))
                | (filt_q & (sync2_q ^ sync3_q));
            prev_q <= filt_q;
        end
    end

    // change against the previously captured value
    // group 3 has seven inputs; its eighth slice bit is the zero pad
    assign pc_chg = {1'b0, filt_q[31:1] ^ prev_q[31:1], 1'b0};
    assign grp_en = mask_q[EPI_GRP_BIT_LO +: EPI_NUM_GROUPS];

    // groups 3 and 2 exist only on the full-pin variant
    generate
        for (genvar g = 0; g < EPI_NUM_GROUPS; g++) begin : g_grp
            // group g spans inputs 8g+7..8g (group 3 ends at 30)
            assign grp_live[g] = FULL_PINS || (g < 2);
            assign grp_set[g] = grp_live[g] && grp_en[g]
                && |(pc_chg[g*EPI_GRP_W+1 +: EPI_GRP_W]
                & pmask_q[g]);
        end
    endgenerate

    // edge terms need the I/O clock; gated off when it stops
    assign ext_now = filt_q[0];
    assign ext_rise = ext_now & ~prev_q[0];
    assign ext_fall = ~ext_now & prev_q[0];
    assign level_mode = (sense_q == EPI_SENSE_LOW);

    // sense decode for the pin
    always_comb begin
        ext_set = 1'b0;
        if (io_clk_run_in) begin
            case (sense_q)
                EPI_SENSE_ANY: ext_set = ext_rise | ext_fall;
                EPI_SENSE_FALL: ext_set = ext_fall;
                EPI_SENSE_RISE: ext_set = ext_rise;
                default: ext_set = 1'b0; // level needs no flag
            endcase
        end
    end

    // write strobes
    assign flag_wr = reg_wr_in && (reg_addr_in == EPI_ADDR_FLAGS);
    assign flag_w1 = flag_wr ? reg_wdata_in : 8'h00;
    assign wsel = pmask_sel(reg_addr_in);
    assign rsel = pmask_sel(reg_addr_in);

    // enable mask; bits 3..1 never store
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mask_q <= EPI_MASK_RST;
        end else if (reg_wr_in && reg_addr_in == EPI_ADDR_MASK) begin
            mask_q <= reg_wdata_in & EPI_MASK_WR_BITS;
        end
    end

    // sense selection
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sense_q <= EPI_SENSE_RST[1:0];
        end else if (reg_wr_in && reg_addr_in == EPI_ADDR_SENSE) begin
            sense_q <= reg_wdata_in[1:0];
        end
    end

    // per-input masks; group 3 has only seven inputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < EPI_NUM_GROUPS; i++) begin
                pmask_q[i] <= EPI_PMASK_RST;
            end
        end else if (reg_wr_in && wsel[2]) begin
            if (wsel[1:0] == 2'h3) begin
                pmask_q[3] <= reg_wdata_in & EPI_PMASK3_WR_BITS;
            end else begin
                pmask_q[wsel[1:0]] <= reg_wdata_in;
            end
        end
    end

    // pin flag: held clear in level mode, set beats clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ext_flag_q <= EPI_FLAGS_RST[EPI_EXT_BIT];
        end else if (level_mode) begin
            ext_flag_q <= 1'b0;
        end else if (ext_set) begin
            ext_flag_q <= 1'b1;
        end else if (ext_irq_ack_in || flag_w1[EPI_EXT_BIT]) begin
            ext_flag_q <= 1'b0;
        end
    end

    // group flags: set on change, cleared by entry or a one
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            grp_flag_q <= EPI_FLAGS_RST[EPI_GRP_BIT_LO +: 4];
        end else begin
            grp_flag_q <= grp_set | (grp_flag_q & ~group_ack_in
                & ~flag_w1[EPI_GRP_BIT_LO +: 4]);
        end
    end

    // read mux; absent registers and reserved bits read zero, except mask bits 7..6 on the reduced part
    always_comb begin
        rd_d = 8'h00;
        if (rsel[2]) begin
            rd_d = grp_live[rsel[1:0]] ? pmask_q[rsel[1:0]] : 8'h00;
        end else begin
            case (reg_addr_in)
                EPI_ADDR_MASK: rd_d = mask_q;
                EPI_ADDR_SENSE: rd_d = {6'h00, sense_q};
                EPI_ADDR_FLAGS: begin
                    rd_d = 8'h00;
                    rd_d[EPI_GRP_BIT_LO +: 4] = grp_flag_q
                        & grp_live;
                    rd_d[EPI_EXT_BIT] = ext_flag_q;
                end
                default: rd_d = 8'h00; // unmapped reads zero
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_q <= EPI_RDATA_RST;
        end else begin
            rdata_q <= reg_rd_in ? rd_d : 8'h00;
        end
    end
    assign reg_rdata_out = rdata_q;

    // requests stay up until the flag drops or enables fall
    assign pin_change_group_request_out =
        grp_flag_q & grp_en & {4{global_irq_enable_in}};
    // level mode requests straight from the sampled pin;
    // a glitch shorter than the sampler is not guaranteed
    assign ext_irq_request_out = global_irq_enable_in
        && mask_q[EPI_EXT_BIT]
        && (level_mode ? ~ext_now : ext_flag_q);

    // clockless wake: raw pins against the last agreed value;
    // a low level that ends before start-up still wakes us but
    // leaves no request behind, since the sampler never sees it
    assign wake_diff = (raw ^ filt_q) & {
        pmask_q[3][6:0] & {7{grp_en[3] & grp_live[3]}},
        pmask_q[2] & {8{grp_en[2] & grp_live[2]}},
        pmask_q[1] & {8{grp_en[1]}},
        pmask_q[0] & {8{grp_en[0]}}, 1'b0};
    assign wake_request_out = (|wake_diff)
        || (mask_q[EPI_EXT_BIT] && level_mode
        && !ext_irq_pin_in);

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_level_request: assert property (
        mask_q[0] && global_irq_enable_in && level_mode && !ext_now
        |-> ext_irq_request_out)
        else $error("level low without request");

    a_level_flag_clr: assert property (
        level_mode |=> !ext_flag_q)
        else $error("pin flag set in level mode");

    a_rise_flag: assert property (
        sense_q == EPI_SENSE_RISE && io_clk_run_in
        && ext_now && !prev_q[0] |=> ext_flag_q)
        else $error("rising edge did not set pin flag");

    a_grp0_set: assert property (
        grp_en[0] && |(pc_chg[8:1] & pmask_q[0]) |=> grp_flag_q[0])
        else $error("group 0 change not flagged");

    a_grp1_set: assert property (
        grp_en[1] && |(pc_chg[16:9] & pmask_q[1]) |=> grp_flag_q[1])
        else $error("group 1 change not flagged");

    a_w1c_clear: assert property (
        flag_wr && reg_wdata_in[4] && !grp_set[0]
        |=> !grp_flag_q[0])
        else $error("written one did not clear group 0 flag");

    a_group_req: assert property (
        $rose(grp_flag_q[1]) && grp_en[1] && global_irq_enable_in
        |-> pin_change_group_request_out[1])
        else $error("group 1 flag did not request");

    a_mask_rsvd: assert property (
        reg_rd_in && reg_addr_in == EPI_ADDR_MASK
        |=> reg_rdata_out[3:1] == 3'h0)
        else $error("reserved mask bits read nonzero");

    a_edge_stopped: assert property (
        !io_clk_run_in && !ext_flag_q |=> !ext_flag_q)
        else $error("edge caught with I/O clock stopped");

    a_pin_sampled: assert property (
        ext_irq_pin_in [*5] |=> ext_now)
        else $error("stable high pin not sampled");

    a_reduced_zero: assert property (
        !FULL_PINS && reg_rd_in && reg_addr_in == EPI_ADDR_FLAGS
        |=> reg_rdata_out[7:6] == 2'h0)
        else $error("reserved flags read nonzero");

    a_grp2_set: assert property (
        grp_live[2] && grp_en[2] && |(pc_chg[24:17] & pmask_q[2])
        |=> grp_flag_q[2])
        else $error("group 2 change not flagged");

    a_grp3_set: assert property (
        grp_live[3] && grp_en[3] && |(pc_chg[31:25] & pmask_q[3][6:0])
        |=> grp_flag_q[3])
        else $error("group 3 change not flagged");

    // neither interrupt request reaches the processor while its global enable is off
    a_global_gate: assert property (
        !global_irq_enable_in |-> !ext_irq_request_out
        && pin_change_group_request_out == 4'h0)
        else $error("request passed with global enable off");

    a_fall_flag: assert property (
        sense_q == EPI_SENSE_FALL && io_clk_run_in
        && !ext_now && prev_q[0] |=> ext_flag_q)
        else $error("falling edge did not set pin flag");

    a_any_flag: assert property (
        sense_q == EPI_SENSE_ANY && io_clk_run_in
        && (ext_now != prev_q[0]) |=> ext_flag_q)
        else $error("pin change did not set pin flag");

    // handler entry with no new event leaves the pin flag clear
    a_ext_ack_clr: assert property (
        ext_irq_ack_in && !ext_set |=> !ext_flag_q)
        else $error("handler entry did not clear pin flag");

    a_pmask3_rsvd: assert property (
        reg_rd_in && reg_addr_in == EPI_ADDR_PMASK3
        |=> reg_rdata_out[7] == 1'b0)
        else $error("unused group 3 mask bit read nonzero");

    c_rise_req: cover property (
        sense_q == EPI_SENSE_RISE ##1 ext_irq_request_out);
    c_grp0_req: cover property (pin_change_group_request_out[0]);
    c_level_req: cover property (
        level_mode && ext_irq_request_out);
    c_w1c: cover property (grp_flag_q[0] && flag_wr ##1 !grp_flag_q[0]);
    c_grp3_req: cover property (pin_change_group_request_out[3]);
endmodule // epi_ctrl

//--- testbench/epi_pin_model.sv
// model of the port pins that feed the interrupt block
`timescale 1ns/1ps
module epi_pin_model (
    // clock
    input wire logic clk_in,
    // port data register update
    input wire logic load_in,
    input wire logic [31:0] value_in,
    // pins as seen by the block
    output logic ext_irq_pin_out,
    output logic [30:0] pin_change_inputs_out
);
    // pins act as outputs, so software writes make the activity
    logic [31:0] port_q = 32'hFFFFFFFF;
    // a level stays put until the next write, never a glitch
    always_ff @(posedge clk_in) begin
        if (load_in) begin
            port_q <= value_in;
        end
    end
    assign ext_irq_pin_out = port_q[31];
    assign pin_change_inputs_out = port_q[30:0];
endmodule // epi_pin_model

//--- testbench/epi_ctrl_tb.sv
// self-checking bench for the external pin interrupt block
`timescale 1ns/1ps
module epi_ctrl_tb;
    import epi_pkg::*;
    localparam logic [31:0] PIN = 32'h80000000; // external pin bit
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] rdata;
    logic gie = 1'b0;
    logic iorun = 1'b1;
    logic eack = 1'b0;
    logic [3:0] gack = 4'h0;
    logic ereq;
    logic [3:0] greq;
    logic wake;
    logic ld = 1'b0;
    logic [31:0] pv = 32'hFFFFFFFF;
    logic [31:0] pins = 32'hFFFFFFFF; // bench copy of the port
    logic epin;
    logic [30:0] pci;
    logic [7:0] rdata_r; // reduced variant read data
    logic [3:0] greq_r; // reduced variant group requests
    logic [7:0] wdata_r; // write data as software gives the reduced part
    int bad_count = 0;
    int n_compared = 0;
    logic [7:0] adr [7] = '{EPI_ADDR_FLAGS, EPI_ADDR_MASK, EPI_ADDR_SENSE,
        EPI_ADDR_PMASK0, EPI_ADDR_PMASK1, EPI_ADDR_PMASK2, EPI_ADDR_PMASK3};

    always #2.5 clk = ~clk;

    epi_pin_model pins_m (.clk_in(clk), .load_in(ld), .value_in(pv),
        .ext_irq_pin_out(epin), .pin_change_inputs_out(pci));

    epi_ctrl #(.FULL_PINS(1'b1)) uut (.clk_in(clk), .rst_in(rst),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .ext_irq_pin_in(epin),
        .pin_change_inputs_in(pci), .global_irq_enable_in(gie),
        .io_clk_run_in(iorun), .ext_irq_ack_in(eack), .group_ack_in(gack),
        .ext_irq_request_out(ereq), .pin_change_group_request_out(greq),
        .wake_request_out(wake));

    // software never sets the reserved group enables of the reduced part
    assign wdata_r = (addr == EPI_ADDR_MASK)
        ? (wdata & 8'h3F) : wdata;

    // reduced-pin variant beside the full one, on the same bus and pins
    epi_ctrl #(.FULL_PINS(1'b0)) uut_red (.clk_in(clk), .rst_in(rst),
        .reg_addr_in(addr), .reg_wdata_in(wdata_r), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(rdata_r), .ext_irq_pin_in(epin),
        .pin_change_inputs_in(pci), .global_irq_enable_in(gie),
        .io_clk_run_in(iorun), .ext_irq_ack_in(eack), .group_ack_in(gack),
        .ext_irq_request_out(), .pin_change_group_request_out(greq_r),
        .wake_request_out());

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    // one-cycle write, taken at the second edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    // read both variants; the reduced one answers in the same cycle
    task automatic rchk2(input logic [7:0] a, input logic [7:0] exp,
        input logic [7:0] exp_r);
        @(posedge clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(rdata, exp);
        chk(rdata_r, exp_r);
    endtask

    task automatic set_pins(input logic [31:0] v);
        pins = v;
        @(posedge clk);
        pv <= v;
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        #1;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // handler entry pulses
    task automatic ack(input logic e, input logic [3:0] g);
        @(posedge clk);
        eack <= e;
        gack <= g;
        @(posedge clk);
        eack <= 1'b0;
        gack <= 4'h0;
        #1;
    endtask

    task automatic t_regs();
        for (int i = 0; i < 7; i++) rchk(adr[i], 8'h00);
        wait_n(1);
        chk(rdata, 8'h00);
        wr(EPI_ADDR_MASK, 8'hFF);
        rchk2(EPI_ADDR_MASK, 8'hF1, 8'h31);
        wr(EPI_ADDR_SENSE, 8'hFF);
        rchk(EPI_ADDR_SENSE, 8'h03);
        wr(EPI_ADDR_PMASK3, 8'hFF);
        rchk2(EPI_ADDR_PMASK3, 8'h7F, 8'h00);
        wr(8'h00, 8'hFF); // unmapped place
        rchk(8'h00, 8'h00);
        for (int i = 1; i < 7; i++) wr(adr[i], 8'h00);
        $display("test regs done");
    endtask

    task automatic t_groups();
        @(posedge clk) gie <= 1'b1;
        wr(EPI_ADDR_MASK, 8'hF0);
        for (int g = 0; g < 4; g++) begin
            wr(EPI_ADDR_PMASK0 + 8'(g), 8'h01);
            set_pins(pins ^ (32'h2 << (8 * g))); // input masked off
            wait_n(6);
            chk(greq, 32'h0);
            set_pins(pins ^ (32'h1 << (8 * g)));
            wait_n(6);
            chk(greq, 32'h1 << g);
            chk(greq_r, 32'h3 & (32'h1 << g));
            rchk2(EPI_ADDR_FLAGS, 8'h10 << g,
                8'h30 & (8'h10 << g));
            wr(EPI_ADDR_FLAGS, 8'h00); // zero leaves the flag
            rchk(EPI_ADDR_FLAGS, 8'h10 << g);
            @(posedge clk) gie <= 1'b0;
            #1 chk(greq, 32'h0);
            @(posedge clk) gie <= 1'b1;
            // odd groups cleared by software, even ones by the handler
            if (g % 2) wr(EPI_ADDR_FLAGS, 8'h10 << g);
            else ack(1'b0, 4'h1 << g);
            chk(greq, 32'h0);
        end
        $display("test groups done");
    endtask

    task automatic t_sense();
        wr(EPI_ADDR_MASK, 8'h01);
        for (int m = 1; m < 4; m++) begin
            wr(EPI_ADDR_SENSE, 8'(m));
            wr(EPI_ADDR_FLAGS, 8'h01);
            set_pins(pins & ~PIN);
            wait_n(6);
            chk(ereq, 32'(m != 3));
            wr(EPI_ADDR_FLAGS, 8'h01);
            chk(ereq, 32'h0);
            set_pins(pins | PIN);
            wait_n(6);
            chk(ereq, 32'(m != 2));
            ack(1'b1, 4'h0);
            chk(ereq, 32'h0);
        end
        wr(EPI_ADDR_SENSE, 8'h00); // low level held for many cycles
        set_pins(pins & ~PIN);
        wait_n(5);
        chk(ereq, 32'h1);
        rchk(EPI_ADDR_FLAGS, 8'h00);
        wait_n(4);
        chk(ereq, 32'h1);
        @(posedge clk) gie <= 1'b0;
        #1 chk(ereq, 32'h0);
        @(posedge clk) gie <= 1'b1;
        set_pins(pins | PIN);
        wait_n(5);
        chk(ereq, 32'h0);
        $display("test sense done");
    endtask

    task automatic t_sleep();
        wr(EPI_ADDR_SENSE, 8'h02);
        wr(EPI_ADDR_FLAGS, 8'h01);
        @(posedge clk) iorun <= 1'b0;
        set_pins(pins & ~PIN); // falling edge with clock halted
        wait_n(6);
        chk(ereq, 32'h0);
        set_pins(pins | PIN);
        @(posedge clk) iorun <= 1'b1;
        wait_n(6);
        wr(EPI_ADDR_MASK, 8'h10);
        set_pins(pins ^ 32'h1);
        chk(wake, 32'h1);
        wait_n(6);
        chk(wake, 32'h0);
        ack(1'b0, 4'h1);
        wr(EPI_ADDR_MASK, 8'h01);
        wr(EPI_ADDR_SENSE, 8'h00);
        @(posedge clk) iorun <= 1'b0;
        set_pins(pins & ~PIN);
        chk(wake, 32'h1);
        set_pins(pins | PIN);
        @(posedge clk) iorun <= 1'b1;
        $display("test sleep done");
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_groups();
        t_sense();
        t_sleep();
        finish_test();
    end
endmodule // epi_ctrl_tb
